/* File: pkg/uir_defs.svh */
`ifndef UIR_DEFS_SVH
`define UIR_DEFS_SVH

// ----------------------------------------------------------------
// register map, byte addresses on the 32-bit register bus
// ----------------------------------------------------------------
`define UIR_ADDR_W         8
`define UIR_OFS_SKIP       8'h14
`define UIR_OFS_STATUS     8'h20
`define UIR_OFS_ENABLE     8'h24
`define UIR_OFS_FORCE      8'h28
`define UIR_OFS_ROUTE      8'h2c
`define UIR_OFS_CAPS       8'h30
`define UIR_OFS_NAK_CTRL   8'h40

// ----------------------------------------------------------------
// reset values, field positions and masks
// ----------------------------------------------------------------
`define UIR_RST_WORD       32'h0000_0000
`define UIR_RST_NAK        4'h0
`define UIR_RST_FLAG       1'b0
`define UIR_EP_BITS        30
`define UIR_BIT_CTRL_OUT   0
`define UIR_BIT_CTRL_IN    1
`define UIR_BIT_FRAME      30
`define UIR_BIT_DEVICE     31
`define UIR_SKIP_MASK      32'h3fff_ffff
`define UIR_CAP_PAD        24'h00_0000
`define UIR_RESP_OKAY      2'b00
`define UIR_RESP_SLVERR    2'b10

// ----------------------------------------------------------------
// timing: frame period in microseconds, clock in MHz
// ----------------------------------------------------------------
`define UIR_FRAME_TIME_US  1000
`define UIR_CLK_MHZ        40
`define UIR_FRAME_CYCLES   (`UIR_FRAME_TIME_US * `UIR_CLK_MHZ)

`endif

/* File: pkg/uir_pkg.sv */
package uir_pkg;
   typedef logic [31:0] uir_word_t;

   // capability word, low byte; upper bits read as zero
   typedef struct packed {
      logic       toggle_debug_present;
      logic       double_buf_capable;
      logic       single_buf_capable;
      logic [4:0] endpoint_count;
   } uir_caps_t;

   // interrupt-on-NAK options
   typedef struct packed {
      logic nak_irq_generic_in;
      logic nak_irq_generic_out;
      logic nak_irq_ctrl_in;
      logic nak_irq_ctrl_out;
   } uir_nak_cfg_t;
endpackage

/* File: pkg/uir_reg_if.sv */
`timescale 1ns/1ps
`include "uir_defs.svh"
// register access strobes between the bus slave and the register file
interface uir_reg_if;
   logic                     wr_en;
   logic [`UIR_ADDR_W-1:0]   wr_addr;
   uir_pkg::uir_word_t       wr_data;
   logic [3:0]               wr_strb;
   logic                     wr_err;
   logic                     rd_en;
   logic [`UIR_ADDR_W-1:0]   rd_addr;
   uir_pkg::uir_word_t       rd_data;
   logic                     rd_err;
   modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_err, rd_data, rd_err);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface

/* File: core/uir_axil_slave.sv */
`timescale 1ns/1ps
`include "uir_defs.svh"
module uir_axil_slave (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   ce,
   input  wire logic [`UIR_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [`UIR_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   uir_reg_if.bus                      regs
);
   logic [`UIR_ADDR_W-1:0] aw_q, next_aw_q, ar_q, next_ar_q;
   logic [31:0]            w_q, next_w_q, next_rdata;
   logic [3:0]             s_q, next_s_q;
   logic                   next_awready, next_wready, next_bvalid;
   logic                   next_arready, next_rvalid;
   logic [1:0]             next_bresp, next_rresp;

   // --------------------------------------------------------------
   // access strobes: a held address and data pair fires once
   // --------------------------------------------------------------
   assign regs.wr_en   = !awready && !wready && !bvalid;
   assign regs.wr_addr = aw_q;
   assign regs.wr_data = w_q;
   assign regs.wr_strb = s_q;
   assign regs.rd_en   = !arready && !rvalid;
   assign regs.rd_addr = ar_q;

   // ready drops after each handshake and returns once the response is accepted,
   // so only one write and one read are ever in flight
   always_comb begin
      next_aw_q    = aw_q;
      next_w_q     = w_q;
      next_s_q     = s_q;
      next_ar_q    = ar_q;
      next_awready = awready;
      next_wready  = wready;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_arready = arready;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (awvalid && awready) begin
         next_aw_q    = awaddr;
         next_awready = 1'b0;
      end
      if (wvalid && wready) begin
         next_w_q    = wdata;
         next_s_q    = wstrb;
         next_wready = 1'b0;
      end
      if (regs.wr_en) begin
         next_bvalid = 1'b1;
         next_bresp  = regs.wr_err ? `UIR_RESP_SLVERR : `UIR_RESP_OKAY;
      end else if (bvalid && bready) begin
         next_bvalid  = 1'b0;
         next_awready = 1'b1;
         next_wready  = 1'b1;
      end
      if (arvalid && arready) begin
         next_ar_q    = araddr;
         next_arready = 1'b0;
      end
      if (regs.rd_en) begin
         next_rvalid = 1'b1;
         next_rdata  = regs.rd_data;
         next_rresp  = regs.rd_err ? `UIR_RESP_SLVERR : `UIR_RESP_OKAY;
      end else if (rvalid && rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_q    <= '0;
         w_q     <= `UIR_RST_WORD;
         s_q     <= '0;
         ar_q    <= '0;
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= `UIR_RESP_OKAY;
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= `UIR_RST_WORD;
         rresp   <= `UIR_RESP_OKAY;
      end else if (ce) begin
         aw_q    <= next_aw_q;
         w_q     <= next_w_q;
         s_q     <= next_s_q;
         ar_q    <= next_ar_q;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end
endmodule

/* File: core/uir_event_gen.sv */
`timescale 1ns/1ps
`include "uir_defs.svh"
module uir_event_gen #(
   parameter int FRAME_CYCLES = `UIR_FRAME_CYCLES,
   parameter int CNT_W        = 16,
   parameter int N_FLAGS      = 4
) (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     ce,
   input  wire logic [`UIR_EP_BITS-1:0]  buf_deactivated,
   input  wire logic [`UIR_EP_BITS-1:0]  skip_done,
   input  wire logic [`UIR_EP_BITS-1:0]  nak_sent,
   input  wire logic                     setup_received,
   input  wire uir_pkg::uir_nak_cfg_t    nak_cfg,
   input  wire logic                     bus_power_stable,
   input  wire logic                     pullup_connected,
   input  wire logic [N_FLAGS-1:0]       state_flags,
   output logic [31:0]                   hw_set
);
   logic [CNT_W-1:0]       frame_cnt, next_frame_cnt;
   logic [N_FLAGS-1:0]     flags_prev;
   logic                   frame_tick;
   logic [`UIR_EP_BITS-1:0] nak_en;

   // --------------------------------------------------------------
   // millisecond timer, free running so the tick keeps its phase
   // --------------------------------------------------------------
   assign frame_tick = (frame_cnt == CNT_W'(FRAME_CYCLES - 1));
   always_comb begin
      next_frame_cnt = frame_tick ? '0 : frame_cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_cnt  <= '0;
         flags_prev <= '0;
      end else if (ce) begin
         frame_cnt  <= next_frame_cnt;
         flags_prev <= state_flags;
      end
   end

   // per-bit NAK option: even endpoint bits are OUT, odd are IN
   genvar i;
   generate
      for (i = 0; i < `UIR_EP_BITS; i++) begin : g_nak
         if (i == `UIR_BIT_CTRL_OUT) begin : g_co
            assign nak_en[i] = nak_cfg.nak_irq_ctrl_out; // RL4
         end else if (i == `UIR_BIT_CTRL_IN) begin : g_ci
            assign nak_en[i] = nak_cfg.nak_irq_ctrl_in; // RL4
         end else if (i % 2 == 0) begin : g_go
            assign nak_en[i] = nak_cfg.nak_irq_generic_out; // RL4
         end else begin : g_gi
            assign nak_en[i] = nak_cfg.nak_irq_generic_in; // RL4
         end
      end
   endgenerate

   // event vector: one cycle per occurrence
   always_comb begin
      hw_set = '0;
      hw_set[`UIR_EP_BITS-1:0] = buf_deactivated | skip_done // RL1 RL2 RL3 RL15
                               | (nak_sent & nak_en); // RL4
      hw_set[`UIR_BIT_CTRL_OUT] = hw_set[`UIR_BIT_CTRL_OUT] | setup_received; // RL1
      hw_set[`UIR_BIT_FRAME] = frame_tick && bus_power_stable && pullup_connected; // RL5
      hw_set[`UIR_BIT_DEVICE] = |(state_flags & ~flags_prev); // RL6
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_frame_gate: assert property (hw_set[`UIR_BIT_FRAME] |-> // RL5
      (bus_power_stable && pullup_connected && frame_cnt == CNT_W'(FRAME_CYCLES - 1)))
      else $error("frame event without power, connect or period end");
   a_nak_masked: assert property ((nak_sent[`UIR_BIT_CTRL_IN] && !nak_cfg.nak_irq_ctrl_in // RL4
      && !buf_deactivated[`UIR_BIT_CTRL_IN] && !skip_done[`UIR_BIT_CTRL_IN])
      |-> !hw_set[`UIR_BIT_CTRL_IN])
      else $error("nak raised control in event while option off");
endmodule

/* File: core/uir_top.sv */
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "uir_defs.svh"
// How it works
// RL1: control OUT bit on count zero, skip, setup
// RL2: control IN bit on count zero or skip
// RL3: endpoint bits 2-29 set when buffer deactivates
// RL4: NAK options also set matching endpoint bit
// RL5: frame bit each millisecond while powered, connected
// RL6: bit 31 on any device status change; code sets it only when a state flag rises from 0 to 1
// RL7: status resets zero, clears on written one
// RL8: interrupt where enable and status both set
// RL9: force-set register writes ones into status
// RL10: force-set register reads back the status
// RL11: routing bit picks normal or fast line
// RL12: capabilities bits 4:0 give endpoint count
// RL13: capabilities bits 5, 6 give buffering support
// RL14: bit 7 toggle debug flag, rest zero
// RL15: skip request deactivates buffer, clears, interrupts
// RL16: each line ORs its routed, enabled bits
// RL17: hardware set beats a same-cycle clear
module uir_top #(
   parameter int         FRAME_CYCLES       = `UIR_FRAME_CYCLES,
   parameter int         N_FLAGS            = 4,
   parameter logic [4:0] ENDPOINT_COUNT     = 5'h1c,
   parameter logic       SINGLE_BUF_CAPABLE = 1'b1,
   parameter logic       DOUBLE_BUF_CAPABLE = 1'b1,
   parameter logic       TOGGLE_DEBUG       = 1'b1
) (
   input  wire logic                    CLK,
   input  wire logic                    RESET_N,
   input  wire logic                    CE,
   input  wire logic [`UIR_ADDR_W-1:0]  AWADDR,
   input  wire logic                    AWVALID,
   output logic                         AWREADY,
   input  wire logic [31:0]             WDATA,
   input  wire logic [3:0]              WSTRB,
   input  wire logic                    WVALID,
   output logic                         WREADY,
   output logic [1:0]                   BRESP,
   output logic                         BVALID,
   input  wire logic                    BREADY,
   input  wire logic [`UIR_ADDR_W-1:0]  ARADDR,
   input  wire logic                    ARVALID,
   output logic                         ARREADY,
   output logic [31:0]                  RDATA,
   output logic [1:0]                   RRESP,
   output logic                         RVALID,
   input  wire logic                    RREADY,
   input  wire logic [`UIR_EP_BITS-1:0] BUF_DEACTIVATED,
   input  wire logic [`UIR_EP_BITS-1:0] SKIP_DONE,
   input  wire logic [`UIR_EP_BITS-1:0] NAK_SENT,
   input  wire logic                    SETUP_RECEIVED,
   input  wire logic                    BUS_POWER_STABLE,
   input  wire logic                    PULLUP_CONNECTED,
   input  wire logic [N_FLAGS-1:0]      DEVICE_STATE_FLAGS,
   output logic [`UIR_EP_BITS-1:0]      SKIP_REQUEST,
   output logic                         NORMAL_INTERRUPT_LINE,
   output logic                         FAST_INTERRUPT_LINE
);
   // --------------------------------------------------------------
   // state and wiring
   // --------------------------------------------------------------
   uir_reg_if regs ();

   uir_pkg::uir_word_t    status, next_status;
   uir_pkg::uir_word_t    enable, next_enable;
   uir_pkg::uir_word_t    route, next_route;
   uir_pkg::uir_word_t    skip, next_skip;
   uir_pkg::uir_nak_cfg_t nak_cfg, next_nak_cfg;
   uir_pkg::uir_caps_t    caps;
   uir_pkg::uir_word_t    hw_set, wr_mask, clr_mask, force_mask, pending;
   logic                  next_normal, next_fast;
   logic                  wr_status, wr_force, wr_enable, wr_route;
   logic                  wr_skip, wr_nak;

   // fixed capability word
   assign caps.endpoint_count       = ENDPOINT_COUNT; // RL12
   assign caps.single_buf_capable   = SINGLE_BUF_CAPABLE; // RL13
   assign caps.double_buf_capable   = DOUBLE_BUF_CAPABLE; // RL13
   assign caps.toggle_debug_present = TOGGLE_DEBUG; // RL14

   // --------------------------------------------------------------
   // bus slave and event collection
   // --------------------------------------------------------------
   uir_axil_slave i_uir_axil_slave (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ce      (CE),
      .awaddr  (AWADDR),
      .awvalid (AWVALID),
      .awready (AWREADY),
      .wdata   (WDATA),
      .wstrb   (WSTRB),
      .wvalid  (WVALID),
      .wready  (WREADY),
      .bresp   (BRESP),
      .bvalid  (BVALID),
      .bready  (BREADY),
      .araddr  (ARADDR),
      .arvalid (ARVALID),
      .arready (ARREADY),
      .rdata   (RDATA),
      .rresp   (RRESP),
      .rvalid  (RVALID),
      .rready  (RREADY),
      .regs    (regs)
   );

   uir_event_gen #(
      .FRAME_CYCLES (FRAME_CYCLES),
      .N_FLAGS      (N_FLAGS)
   ) i_uir_event_gen (
      .clk              (CLK),
      .reset_n          (RESET_N),
      .ce               (CE),
      .buf_deactivated  (BUF_DEACTIVATED),
      .skip_done        (SKIP_DONE),
      .nak_sent         (NAK_SENT),
      .setup_received   (SETUP_RECEIVED),
      .nak_cfg          (nak_cfg),
      .bus_power_stable (BUS_POWER_STABLE),
      .pullup_connected (PULLUP_CONNECTED),
      .state_flags      (DEVICE_STATE_FLAGS),
      .hw_set           (hw_set)
   );

   // --------------------------------------------------------------
   // write decode; byte strobes gate every bit that a write touches
   // --------------------------------------------------------------
   assign wr_mask   = {{8{regs.wr_strb[3]}}, {8{regs.wr_strb[2]}},
                       {8{regs.wr_strb[1]}}, {8{regs.wr_strb[0]}}};
   assign wr_status = regs.wr_en && (regs.wr_addr == `UIR_OFS_STATUS);
   assign wr_enable = regs.wr_en && (regs.wr_addr == `UIR_OFS_ENABLE);
   assign wr_force  = regs.wr_en && (regs.wr_addr == `UIR_OFS_FORCE);
   assign wr_route  = regs.wr_en && (regs.wr_addr == `UIR_OFS_ROUTE);
   assign wr_skip   = regs.wr_en && (regs.wr_addr == `UIR_OFS_SKIP);
   assign wr_nak    = regs.wr_en && (regs.wr_addr == `UIR_OFS_NAK_CTRL);
   assign clr_mask   = wr_status ? (regs.wr_data & wr_mask) : `UIR_RST_WORD; // RL7
   assign force_mask = wr_force ? (regs.wr_data & wr_mask) : `UIR_RST_WORD; // RL9
   assign pending    = status & enable; // RL8

   // writes to the read-only capability word are accepted and dropped
   assign regs.wr_err = !(wr_status || wr_enable || wr_force || wr_route
                          || wr_skip || wr_nak
                          || regs.wr_addr == `UIR_OFS_CAPS);

   // --------------------------------------------------------------
   // register next values
   // --------------------------------------------------------------
   always_comb begin
      // clear first, then both set sources, so an event never gets lost
      next_status = (status & ~clr_mask) | hw_set | force_mask; // RL7 RL9 RL17
      next_enable = wr_enable ? ((enable & ~wr_mask) | (regs.wr_data & wr_mask))
                              : enable; // RL8
      next_route  = wr_route ? ((route & ~wr_mask) | (regs.wr_data & wr_mask))
                             : route; // RL11
      // engine completion clears the request; a new write in the same
      // cycle is lost for that bit, the engine has already acted on it
      next_skip   = wr_skip ? ((skip & ~wr_mask) | (regs.wr_data & wr_mask)) : skip;
      next_skip   = next_skip & ~{2'b00, SKIP_DONE} & `UIR_SKIP_MASK; // RL15
      next_nak_cfg = nak_cfg;
      if (wr_nak && regs.wr_strb[0]) begin
         next_nak_cfg = uir_pkg::uir_nak_cfg_t'(regs.wr_data[3:0]); // RL4
      end
      // registered lines: one cycle behind the status word
      next_normal = |(pending & ~route); // RL11 RL16
      next_fast   = |(pending & route); // RL11 RL16
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         status                <= `UIR_RST_WORD; // RL7
         enable                <= `UIR_RST_WORD; // RL8
         route                 <= `UIR_RST_WORD; // RL11
         skip                  <= `UIR_RST_WORD;
         nak_cfg               <= uir_pkg::uir_nak_cfg_t'(`UIR_RST_NAK);
         NORMAL_INTERRUPT_LINE <= `UIR_RST_FLAG;
         FAST_INTERRUPT_LINE   <= `UIR_RST_FLAG;
      end else if (CE) begin
         status                <= next_status;
         enable                <= next_enable;
         route                 <= next_route;
         skip                  <= next_skip;
         nak_cfg               <= next_nak_cfg;
         NORMAL_INTERRUPT_LINE <= next_normal;
         FAST_INTERRUPT_LINE   <= next_fast;
      end
   end

   // the request register is a flop, so the output needs no extra stage
   assign SKIP_REQUEST = skip[`UIR_EP_BITS-1:0]; // RL15

   // --------------------------------------------------------------
   // read mux; reads have no side effect on any register
   // --------------------------------------------------------------
   always_comb begin
      regs.rd_data = `UIR_RST_WORD;
      regs.rd_err  = 1'b0;
      unique case (regs.rd_addr)
         `UIR_OFS_STATUS:   regs.rd_data = status;
         `UIR_OFS_ENABLE:   regs.rd_data = enable;
         `UIR_OFS_FORCE:    regs.rd_data = status; // RL10
         `UIR_OFS_ROUTE:    regs.rd_data = route;
         `UIR_OFS_SKIP:     regs.rd_data = skip;
         `UIR_OFS_CAPS:     regs.rd_data = {`UIR_CAP_PAD, caps}; // RL12 RL13 RL14
         `UIR_OFS_NAK_CTRL: regs.rd_data = {28'h000_0000, nak_cfg};
         default:           regs.rd_err  = 1'b1;
      endcase
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   a_set_beats_clear: assert property ( // RL17
      (CE && wr_status && (hw_set & regs.wr_data & wr_mask) != '0)
      |=> ((status & $past(hw_set)) == $past(hw_set)))
      else $error("hardware event lost to a same-cycle clear");

   a_w1c_clears: assert property ( // RL7
      (CE && wr_status && hw_set == '0)
      |=> (status == ($past(status) & ~$past(clr_mask))))
      else $error("status clear by writing ones misbehaved");

   a_no_stray_set: assert property ( // RL7
      CE |=> ((status & ~$past(status) & ~$past(hw_set) & ~$past(force_mask)) == '0))
      else $error("status bit rose without a set source");

   a_force_sets: assert property ( // RL9
      (CE && force_mask != '0) |=> ((status & $past(force_mask)) == $past(force_mask)))
      else $error("force-set write did not raise status");

   a_force_reads_status: assert property ( // RL10
      (CE && regs.rd_en && regs.rd_addr == `UIR_OFS_FORCE)
      |=> (RVALID && RDATA == $past(status)))
      else $error("force-set read did not return status");

   a_normal_line: assert property ( // RL16
      CE |=> (NORMAL_INTERRUPT_LINE == |($past(status) & $past(enable) & ~$past(route))))
      else $error("normal line does not match routed pending bits");

   a_fast_line: assert property ( // RL11
      (CE && (status & enable & route) == '0) |=> !FAST_INTERRUPT_LINE)
      else $error("fast line high without a fast-routed pending bit");

   a_caps_word: assert property ( // RL14
      (CE && regs.rd_en && regs.rd_addr == `UIR_OFS_CAPS)
      |=> (RDATA[31:8] == `UIR_CAP_PAD && RDATA[4:0] == ENDPOINT_COUNT))
      else $error("capability word read back wrong");

   a_skip_retires: assert property ( // RL15
      (CE && SKIP_DONE != '0)
      ##1 (CE && SKIP_DONE == '0 && !wr_skip)
      |-> ((SKIP_REQUEST & $past(SKIP_DONE)) == '0) && ((status & {2'b00, $past(SKIP_DONE)})
      == {2'b00, $past(SKIP_DONE)}))
      else $error("skip completion did not clear request or raise status");

   a_enable_reset: assert property ( // RL8
      (CE && enable == '0) |=> (!NORMAL_INTERRUPT_LINE && !FAST_INTERRUPT_LINE))
      else $error("interrupt line high with every enable bit clear");
endmodule

/* File: verif/uir_engine_model.sv */
`timescale 1ns/1ps
module uir_engine_model (
   input  wire logic        clk,
   input  wire logic [29:0] skip_request,
   output logic      [29:0] skip_done
);
   int cnt = 0;
   // buffer drops a few cycles after the request, then reports done once
   always @(posedge clk) begin
      skip_done <= '0;
      if (skip_request == '0) cnt <= 0;
      else if (cnt == 3) begin
         skip_done <= skip_request;
         cnt <= 0;
      end else cnt <= cnt + 1;
   end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic CLK = 0, RESET_N = 0, CE = 1, AWVALID = 0, WVALID = 0, BREADY = 1;
   logic ARVALID = 0, RREADY = 1, SETUP_RECEIVED = 0;
   logic BUS_POWER_STABLE = 0, PULLUP_CONNECTED = 0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic NORMAL_INTERRUPT_LINE, FAST_INTERRUPT_LINE;
   logic [7:0]  AWADDR = 0, ARADDR = 0;
   logic [3:0]  WSTRB = 4'hf, DEVICE_STATE_FLAGS = 0;
   logic [1:0]  BRESP, RRESP, e;
   logic [31:0] WDATA = 0, RDATA, v, m, r, c, d;
   logic [29:0] BUF_DEACTIVATED = 0, NAK_SENT = 0, SKIP_DONE, SKIP_REQUEST;
   int          err_count = 0, compares = 0, k;
   always #12.5 CLK = ~CLK;
   uir_top #(.FRAME_CYCLES(20)) i_uir_top (.CLK, .RESET_N, .CE, .AWADDR, .AWVALID,
      .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
      .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .BUF_DEACTIVATED, .SKIP_DONE,
      .NAK_SENT, .SETUP_RECEIVED, .BUS_POWER_STABLE, .PULLUP_CONNECTED,
      .DEVICE_STATE_FLAGS, .SKIP_REQUEST, .NORMAL_INTERRUPT_LINE, .FAST_INTERRUPT_LINE);
   uir_engine_model i_uir_engine_model (.clk(CLK), .skip_request(SKIP_REQUEST),
      .skip_done(SKIP_DONE));
   // ---------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge CLK);
      AWADDR <= a; WDATA <= w; AWVALID <= 1; WVALID <= 1;
      fork
         begin do @(posedge CLK); while (!AWREADY); AWVALID <= 0; end
         begin do @(posedge CLK); while (!WREADY); WVALID <= 0; end
      join
      do @(posedge CLK); while (!BVALID);
      e = BRESP;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] e);
      @(posedge CLK);
      ARADDR <= a; ARVALID <= 1;
      do @(posedge CLK); while (!ARREADY);
      ARVALID <= 0;
      do @(posedge CLK); while (!RVALID);
      q = RDATA; e = RRESP;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rc(input logic [7:0] a, input logic [31:0] exp);
      logic [1:0] e;
      rd(a, d, e);
      chk(d, exp);
   endtask
   // one-cycle event pulses on the endpoint inputs
   task ev(input logic [29:0] b, input logic [29:0] n);
      @(posedge CLK); BUF_DEACTIVATED <= b; NAK_SENT <= n;
      @(posedge CLK); BUF_DEACTIVATED <= 0; NAK_SENT <= 0;
   endtask
   // expected line level: enabled set bits routed to the chosen line
   function logic irq(input logic [31:0] s, e, t, input logic f);
      return |(s & e & (f ? t : ~t));
   endfunction
   task end_sim;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(68242));
      repeat (10) @(posedge CLK);
      RESET_N <= 1;
      rc(8'h20, 0);
      rc(8'h24, 0);
      rc(8'h2c, 0);
      wr(8'h30, '1);
      chk(e, 2'b00);
      rc(8'h30, 32'h0000_00fc);
      v = $urandom; m = $urandom; r = $urandom; c = $urandom;
      wr(8'h28, v);
      rc(8'h20, v);
      rc(8'h28, v);
      wr(8'h24, m);
      wr(8'h2c, r);
      repeat (3) @(posedge CLK);
      chk(NORMAL_INTERRUPT_LINE, irq(v, m, r, 0));
      chk(FAST_INTERRUPT_LINE, irq(v, m, r, 1));
      wr(8'h20, c);
      rc(8'h20, v & ~c);
      wr(8'h20, '1);
      rd(8'h44, d, e);
      chk(e, 2'b10);
      wr(8'h44, 0);
      chk(e, 2'b10);
      k = 2 + $urandom % 28;
      ev(30'h1 << k, 0);
      rc(8'h20, 32'h1 << k);
      wr(8'h20, '1);
      @(posedge CLK); SETUP_RECEIVED <= 1;
      @(posedge CLK); SETUP_RECEIVED <= 0;
      rc(8'h20, 1);
      wr(8'h20, '1);
      // the event lands in the very cycle of the clear strobe
      fork
         wr(8'h20, '1);
         begin repeat (2) @(posedge CLK); SETUP_RECEIVED <= 1;
            @(posedge CLK); SETUP_RECEIVED <= 0; end
      join
      rc(8'h20, 1);
      wr(8'h20, '1);
      ev(30'h2, 0);
      rc(8'h20, 2);
      wr(8'h20, '1);
      DEVICE_STATE_FLAGS <= 4'h4;
      rc(8'h20, 32'h8000_0000);
      wr(8'h20, '1);
      ev(0, '1);
      rc(8'h20, 0);
      wr(8'h40, 32'hf);
      ev(0, '1);
      rc(8'h20, 32'h3fff_ffff);
      wr(8'h20, '1);
      wr(8'h14, 32'h1 << k);
      repeat (10) @(posedge CLK);
      rc(8'h20, 32'h1 << k);
      rc(8'h14, 0);
      BUS_POWER_STABLE <= 1; PULLUP_CONNECTED <= 1;
      wr(8'h20, '1);
      repeat (25) @(posedge CLK);
      rc(8'h20, 32'h4000_0000);
      PULLUP_CONNECTED <= 0;
      wr(8'h20, '1);
      repeat (45) @(posedge CLK);
      rc(8'h20, 0);
      end_sim;
   end
   // watchdog against a hung handshake
   initial begin
      #125000;
      err_count++;
      end_sim;
   end
endmodule
